// >>> design/flash_prog_pkg.sv
// Shared constants for the flash programming port and its security lock
package flash_prog_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int PERIOD_W = 16;
  // Low bits of the reset command: start bit plus eight zero data bits
  localparam int CAL_BITS = 9;
  localparam int BIT_IDX_W = 4;
  localparam logic [BIT_IDX_W-1:0] STOP_IDX = 4'h9;
  localparam logic [BIT_IDX_W-1:0] CAL_LAST = 4'h8;
  // Command opcodes
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_WRITE = 8'h40;
  localparam logic [7:0] OP_SECURE = 8'hA0;
  // Status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_PROT = 2'h1;
  localparam logic [1:0] ST_OVERRUN = 2'h2;
  localparam logic [1:0] ST_CMDERR = 2'h3;
  // Channel clock source codes
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_FAST_OSC = 2'h1;
  localparam logic [1:0] CLK_CRYSTAL = 2'h2;
  localparam logic [1:0] CLK_EXT_MAIN = 2'h3;
  // Reset values
  localparam logic LOCK_RST = 1'b0;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
endpackage : flash_prog_pkg

// >>> design/byte_stream_if.sv
// Valid/ready byte stream between the command path and its FIFO
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// >>> design/stream_fifo.sv
// Small synchronous FIFO with registered ready and valid flags
`timescale 1ns/10ps
module stream_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  byte_stream_if.snk push_s,
  byte_stream_if.src pop_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
    logic out_vld;
  } fifo_s;

  fifo_s q_reg;
  fifo_s q_next;
  logic push;
  logic pop;

  // Pointers wrap naturally, so depth must be a power of two
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
      $error("stream_fifo: DEPTH must be a power of two >= 2");
    end
  end

  assign push = push_s.valid & q_reg.in_rdy;
  assign pop = q_reg.out_vld & pop_s.ready;
  assign push_s.ready = q_reg.in_rdy;
  assign pop_s.valid = q_reg.out_vld;
  assign pop_s.data = q_reg.mem[q_reg.rp];

  // Next state: store, advance pointers, refresh flags
  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.mem[q_reg.wp] = push_s.data;
      q_next.wp = q_reg.wp + 1'b1;
    end
    if (pop) begin
      q_next.rp = q_reg.rp + 1'b1;
    end
    q_next.cnt = q_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    q_next.in_rdy = (q_next.cnt != FULL_CNT);
    q_next.out_vld = (q_next.cnt != '0);
  end

  // State register; empty after reset, so ready is high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= '0;
      q_reg.in_rdy <= 1'b1;
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end
endmodule : stream_fifo

// >>> design/flash_program_port_security.sv
// Flash programming port: clock choice, baud calibration, erase lock
// Contract
// RL1: Clocked serial channel runs only from the internal fast oscillator clock.
// RL2: Async serial channel runs only from crystal or external main clock.
// RL3: After mode-select pulse, receive bit time is measured from reset command.
// RL4: Once security lock is set, every later erase request is refused.
// RL5: While locked, a write may not change a location to different data.
// RL6: A refused erase answers the programmer with protection-error status.
`timescale 1ns/10ps
module flash_program_port_security
  import flash_prog_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flash_mode_select_pin_i,
  input wire logic link_sel_i,
  input wire logic ext_main_clk_sel_i,
  input wire logic rxd_i,
  input wire logic [7:0] csi_data_i,
  input wire logic csi_valid_i,
  output logic csi_ready_o,
  input wire logic security_lock_i,
  input wire logic fl_busy_i,
  input wire logic [7:0] fl_rdata_i,
  output logic [1:0] chan_clk_sel_o,
  output logic [PERIOD_W-1:0] bit_period_o,
  output logic fl_erase_o,
  output logic fl_write_o,
  output logic [7:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  output logic [1:0] status_o,
  output logic status_valid_o,
  output logic lock_o
);
  typedef enum logic [1:0] {M_IDLE, M_CAL_WAIT, M_CAL_MEAS, M_RUN} mode_e;
  typedef enum logic [1:0] {C_OP, C_ADDR, C_DATA} cmd_e;

  typedef struct packed {
    logic [1:0] msel_sync;
    logic msel_prev;
    logic [1:0] rx_sync;
    logic rx_prev;
    mode_e mode;
    cmd_e cmd;
    logic async_mode;
    logic [1:0] clk_sel;
    logic [PERIOD_W-1:0] period;
    logic [BIT_IDX_W-1:0] div9;
    logic [PERIOD_W-1:0] tick;
    logic [BIT_IDX_W-1:0] bitn;
    logic rx_busy;
    logic [7:0] shreg;
    logic byte_vld;
    logic [7:0] byte_dat;
    logic lock;
    logic erase;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] status;
    logic stat_vld;
  } top_s;

  top_s q_reg;
  top_s q_next;
  logic msel_rise;
  logic rx_fall;
  logic rx_rise;
  logic rx_lvl;
  logic pop;
  logic [7:0] pop_byte;

  byte_stream_if #(.W(BYTE_W)) in_s ();
  byte_stream_if #(.W(BYTE_W)) out_s ();
  initial begin
    if (BYTE_W != 8 || PERIOD_W < 4) begin
      $error("flash_program_port_security: unsupported widths");
    end
  end

  stream_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_s(in_s.snk),
    .pop_s(out_s.src)
  );

  // Edges are taken from the second synchroniser stage only
  assign rx_lvl = q_reg.rx_sync[1];
  assign msel_rise = q_reg.msel_sync[1] & ~q_reg.msel_prev;
  assign rx_fall = q_reg.rx_prev & ~rx_lvl;
  assign rx_rise = ~q_reg.rx_prev & rx_lvl;

  // FIFO feed: UART bytes in async mode, clocked channel bytes otherwise
  assign in_s.valid = q_reg.async_mode ? q_reg.byte_vld : csi_valid_i;
  assign in_s.data = q_reg.async_mode ? q_reg.byte_dat : csi_data_i;

  // Command engine stalls on a busy flash and while a pulse is out
  assign out_s.ready = (q_reg.mode == M_RUN) & ~fl_busy_i & ~q_reg.erase &
                       ~q_reg.wr;
  assign pop = out_s.valid & out_s.ready;
  assign pop_byte = out_s.data;

  // Next state of the whole block
  always_comb begin
    q_next = q_reg;
    q_next.byte_vld = 1'b0;
    q_next.erase = 1'b0;
    q_next.wr = 1'b0;
    q_next.stat_vld = 1'b0;
    q_next.msel_sync = {q_reg.msel_sync[0], flash_mode_select_pin_i};
    q_next.rx_sync = {q_reg.rx_sync[0], rxd_i};
    q_next.msel_prev = q_reg.msel_sync[1];
    q_next.rx_prev = rx_lvl;
    q_next.lock = q_reg.lock | security_lock_i;

    unique case (q_reg.mode)
      M_IDLE: begin
        if (msel_rise) begin
          q_next.async_mode = link_sel_i;
          if (link_sel_i) begin
            q_next.clk_sel = ext_main_clk_sel_i ? CLK_EXT_MAIN :
                             CLK_CRYSTAL; // [RL2]
            q_next.mode = M_CAL_WAIT;
          end else begin
            q_next.clk_sel = CLK_FAST_OSC; // [RL1]
            q_next.mode = M_RUN;
          end
        end
      end
      M_CAL_WAIT: begin
        // Reset command starts: begin timing its low span
        if (rx_fall) begin // [RL3]
          q_next.mode = M_CAL_MEAS;
          q_next.period = PERIOD_RST;
          q_next.div9 = '0;
        end
      end
      M_CAL_MEAS: begin
        // One period step every CAL_BITS cycles of low line
        if (rx_rise) begin // [RL3]
          if (q_reg.period == '0) begin
            q_next.period = PERIOD_W'(1);
          end
          q_next.mode = M_RUN;
        end else if (q_reg.div9 == CAL_LAST) begin
          q_next.div9 = '0;
          if (q_reg.period != '1) begin
            q_next.period = q_reg.period + 1'b1;
          end
        end else begin
          q_next.div9 = q_reg.div9 + 1'b1;
        end
      end
      M_RUN: begin
        // UART receiver timed by the calibrated bit period
        if (q_reg.async_mode) begin
          if (!q_reg.rx_busy) begin
            if (rx_fall) begin
              q_next.rx_busy = 1'b1;
              q_next.tick = q_reg.period >> 1;
              q_next.bitn = '0;
            end
          end else if (q_reg.tick != '0) begin
            q_next.tick = q_reg.tick - 1'b1;
          end else begin
            q_next.tick = q_reg.period - 1'b1;
            q_next.bitn = q_reg.bitn + 1'b1;
            if (q_reg.bitn == '0) begin
              q_next.rx_busy = ~rx_lvl;
            end else if (q_reg.bitn != STOP_IDX) begin
              q_next.shreg = {rx_lvl, q_reg.shreg[7:1]};
            end else begin
              q_next.rx_busy = 1'b0;
              q_next.byte_vld = rx_lvl;
              q_next.byte_dat = q_reg.shreg;
            end
          end
        end
      end
    endcase

    // Byte lost to a full FIFO is reported
    if (q_reg.async_mode && q_reg.byte_vld && !in_s.ready) begin
      q_next.status = ST_OVERRUN;
      q_next.stat_vld = 1'b1;
    end

    // Command decode
    if (pop) begin
      unique case (q_reg.cmd)
        C_OP: begin
          q_next.stat_vld = 1'b1;
          q_next.status = ST_OK;
          if (pop_byte == OP_ERASE) begin
            if (q_reg.lock) begin
              q_next.status = ST_PROT; // [RL4] [RL6]
            end else begin
              q_next.erase = 1'b1;
            end
          end else if (pop_byte == OP_WRITE) begin
            q_next.stat_vld = 1'b0;
            q_next.cmd = C_ADDR;
          end else if (pop_byte == OP_SECURE) begin
            q_next.lock = 1'b1;
          end else if (pop_byte != OP_RESET) begin
            q_next.status = ST_CMDERR;
          end
        end
        C_ADDR: begin
          q_next.addr = pop_byte;
          q_next.cmd = C_DATA;
        end
        C_DATA: begin
          q_next.cmd = C_OP;
          q_next.stat_vld = 1'b1;
          // Locked: only a write that matches stored data goes through
          if (q_reg.lock && pop_byte != fl_rdata_i) begin
            q_next.status = ST_PROT; // [RL5]
          end else begin
            q_next.status = ST_OK;
            q_next.wr = 1'b1;
            q_next.wdata = pop_byte;
          end
        end
        default: begin
          q_next.cmd = C_OP;
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= '0;
      q_reg.rx_sync <= 2'b11;
      q_reg.rx_prev <= 1'b1;
      q_reg.lock <= LOCK_RST;
      q_reg.clk_sel <= CLK_NONE;
      q_reg.mode <= M_IDLE;
      q_reg.cmd <= C_OP;
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end

  // Outputs straight from the state register; csi_ready_o from the FIFO's registered ready flag
  assign csi_ready_o = in_s.ready;
  assign chan_clk_sel_o = q_reg.clk_sel;
  assign bit_period_o = q_reg.period;
  assign fl_erase_o = q_reg.erase;
  assign fl_write_o = q_reg.wr;
  assign fl_addr_o = q_reg.addr;
  assign fl_wdata_o = q_reg.wdata;
  assign status_o = q_reg.status;
  assign status_valid_o = q_reg.stat_vld;
  assign lock_o = q_reg.lock;
  // Checks on clock choice, calibration and the lock
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence erase_refused_s;
    ce_i && pop && q_reg.cmd == C_OP && pop_byte == OP_ERASE && q_reg.lock;
  endsequence
  sequence cal_start_s;
    ce_i && q_reg.mode == M_CAL_WAIT && rx_fall;
  endsequence
  clk_csi_a: assert property ( // [RL1]
    (q_reg.mode == M_RUN && !q_reg.async_mode) |->
      chan_clk_sel_o == CLK_FAST_OSC)
    else $error("clocked channel not on fast oscillator");
  clk_uart_a: assert property ( // [RL2]
    (q_reg.mode != M_IDLE && q_reg.async_mode) |->
      (chan_clk_sel_o == CLK_CRYSTAL || chan_clk_sel_o == CLK_EXT_MAIN))
    else $error("async channel on wrong clock");
  cal_entry_a: assert property ( // [RL3]
    cal_start_s |=> (q_reg.mode == M_CAL_MEAS && bit_period_o == '0))
    else $error("calibration did not start on reset command");
  cal_hold_a: assert property ( // [RL3]
    (q_reg.async_mode && q_reg.mode == M_RUN && $past(q_reg.mode) == M_RUN)
      |-> ($stable(bit_period_o) && bit_period_o != '0))
    else $error("bit period changed after calibration");
  erase_lock_a: assert property ( // [RL4]
    q_reg.lock |=> !fl_erase_o)
    else $error("erase issued while locked");
  lock_sticky_a: assert property ( // [RL4]
    q_reg.lock |=> lock_o)
    else $error("security lock dropped");
  write_lock_a: assert property ( // [RL5]
    (ce_i && pop && q_reg.cmd == C_DATA && q_reg.lock) |=>
      (!fl_write_o || fl_wdata_o == $past(fl_rdata_i)))
    else $error("locked write changed flash data");
  prot_status_a: assert property ( // [RL6]
    erase_refused_s |=> (status_valid_o && status_o == ST_PROT && !fl_erase_o))
    else $error("refused erase without protection status");
endmodule : flash_program_port_security

// >>> sim/prog_model.sv
// Model of the external programmer: mode pulse and UART frames
`timescale 1ns/10ps
module prog_model (
  input wire logic core_clk_i,
  output logic mode_pin_o,
  output logic rxd_o
);
  // Idle: mode pin low, UART line high
  initial begin
    mode_pin_o = 1'b0;
    rxd_o = 1'b1;
  end

  // Mode-select pulse, four clocks wide
  task automatic pulse();
    @(negedge core_clk_i) mode_pin_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    mode_pin_o = 1'b0;
  endtask : pulse

  // One 8N1 frame, LSB first, each bit held bt clocks, then a gap
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk_i) rxd_o = fr[i];
      repeat (bt - 1) @(negedge core_clk_i);
    end
    repeat (bt) @(negedge core_clk_i);
  endtask : send

  // Mode pulse, then the all-zero reset command that sets the baud
  task automatic open_session(input int bt);
    pulse();
    repeat (4) @(negedge core_clk_i);
    rxd_o = 1'b0;
    // Low a little past nine bits so the floored period is not marginal
    repeat (9 * bt + 4) @(negedge core_clk_i);
    rxd_o = 1'b1;
    repeat (2 * bt) @(negedge core_clk_i);
  endtask : open_session
endmodule : prog_model

// >>> sim/flash_program_port_security_tb_top.sv
// Self-checking bench for the flash programming port and erase lock
`timescale 1ns/10ps
module flash_program_port_security_tb_top;
  import flash_prog_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_sel = 1'b0;
  logic ext_sel = 1'b0;
  logic [7:0] csi_data = 8'h00;
  logic csi_valid = 1'b0;
  logic lock_strap = 1'b0;
  logic busy = 1'b0;
  logic mode_pin, rxd, csi_ready, erase, write, st_valid, lock;
  logic [1:0] clk_sel, status, last_st;
  logic [PERIOD_W-1:0] period;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] mem [256];
  int n_fail = 0;
  int num_checks = 0;
  int n_er = 0;
  int n_wr = 0;
  int er0, wr0;
  bit uart = 1'b0;
  int bt = 8;

  always #20 core_clk_i = ~core_clk_i;

  prog_model prog_model_i (.core_clk_i(core_clk_i), .mode_pin_o(mode_pin),
    .rxd_o(rxd));
  flash_program_port_security flash_program_port_security_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .flash_mode_select_pin_i(mode_pin), .link_sel_i(link_sel),
    .ext_main_clk_sel_i(ext_sel), .rxd_i(rxd), .csi_data_i(csi_data),
    .csi_valid_i(csi_valid), .csi_ready_o(csi_ready),
    .security_lock_i(lock_strap), .fl_busy_i(busy), .fl_rdata_i(rdata),
    .chan_clk_sel_o(clk_sel), .bit_period_o(period), .fl_erase_o(erase),
    .fl_write_o(write), .fl_addr_o(addr), .fl_wdata_o(wdata),
    .status_o(status), .status_valid_o(st_valid), .lock_o(lock));

  // Flash array model: counts pulses and keeps the last status
  always @(posedge core_clk_i) begin
    if (erase === 1'b1) begin
      n_er++;
      foreach (mem[i]) mem[i] = 8'hFF;
    end
    if (write === 1'b1) begin
      n_wr++;
      mem[addr] = wdata;
    end
    if (st_valid === 1'b1) last_st = status;
  end
  assign rdata = mem[addr];

  task automatic check(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic do_reset();
    @(negedge core_clk_i) rst_i = 1'b1;
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
  endtask : do_reset

  // One byte over the selected link; csi side holds valid until taken
  task automatic put(input logic [7:0] b);
    if (uart) begin
      prog_model_i.send(b, bt);
    end else begin
      @(negedge core_clk_i) csi_data = b;
      csi_valid = 1'b1;
      while (csi_ready !== 1'b1) @(negedge core_clk_i);
      @(negedge core_clk_i) csi_valid = 1'b0;
    end
  endtask : put

  task automatic mark();
    er0 = n_er;
    wr0 = n_wr;
    last_st = 2'bxx;
  endtask : mark

  // Waits for the command to finish, then judges status and pulses
  task automatic expect_out(input string nm, input logic [1:0] st,
                            input int de, input int dw);
    repeat (12) @(negedge core_clk_i);
    check({nm, " status"}, {14'h0000, last_st}, {14'h0000, st});
    check({nm, " erases"}, 16'(n_er - er0), 16'(de));
    check({nm, " writes"}, 16'(n_wr - wr0), 16'(dw));
  endtask : expect_out

  task automatic t_reset();
    check("ready", {15'h0000, csi_ready}, 16'h0001);
    check("clk sel", {14'h0000, clk_sel}, 16'h0000);
    check("lock", {15'h0000, lock}, 16'h0000);
  endtask : t_reset

  // Clocked link: stalled queue fills, then strap lock refuses erase
  task automatic t_csi();
    uart = 1'b0;
    prog_model_i.pulse();
    repeat (4) @(negedge core_clk_i);
    check("csi clk", {14'h0000, clk_sel}, {14'h0000, CLK_FAST_OSC});
    busy = 1'b1;
    mark();
    put(OP_ERASE);
    put(OP_WRITE);
    put(8'h05);
    put(8'h33);
    check("full", {15'h0000, csi_ready}, 16'h0000);
    busy = 1'b0;
    expect_out("queued", ST_OK, 1, 1);
    check("mem queued", {8'h00, mem[5]}, 16'h0033);
    @(negedge core_clk_i) lock_strap = 1'b1;
    @(negedge core_clk_i) lock_strap = 1'b0;
    mark();
    put(OP_ERASE);
    expect_out("csi locked erase", ST_PROT, 0, 0);
    mark();
    put(OP_WRITE);
    put(8'h05);
    put(8'h44);
    expect_out("csi locked write", ST_PROT, 0, 0);
  endtask : t_csi

  // UART on external main clock, lock by command
  task automatic t_uart();
    do_reset();
    uart = 1'b1;
    link_sel = 1'b1;
    ext_sel = 1'b1;
    bt = 12;
    prog_model_i.open_session(bt);
    check("ext clk", {14'h0000, clk_sel}, {14'h0000, CLK_EXT_MAIN});
    check("period 12", period, 16'h000C);
    put(OP_SECURE);
    repeat (8) @(negedge core_clk_i);
    check("lock set", {15'h0000, lock}, 16'h0001);
    mark();
    put(OP_ERASE);
    expect_out("uart locked erase", ST_PROT, 0, 0);
    mark();
    put(OP_WRITE);
    put(8'h05);
    put(8'h33);
    expect_out("same data", ST_OK, 0, 1);
    check("mem same", {8'h00, mem[5]}, 16'h0033);
    mark();
    put(OP_WRITE);
    put(8'h05);
    put(8'h34);
    expect_out("new data", ST_PROT, 0, 0);
    check("mem kept", {8'h00, mem[5]}, 16'h0033);
    mark();
    put(8'h11);
    expect_out("bad op", ST_CMDERR, 0, 0);
  endtask : t_uart

  // UART on crystal clock; lock gone after reset
  task automatic t_crystal();
    do_reset();
    ext_sel = 1'b0;
    bt = 7;
    prog_model_i.open_session(bt);
    check("xtal clk", {14'h0000, clk_sel}, {14'h0000, CLK_CRYSTAL});
    check("period 7", period, 16'h0007);
    mark();
    put(OP_ERASE);
    expect_out("open erase", ST_OK, 1, 0);
  endtask : t_crystal

  // Stalled queue on UART: fifth byte is lost and reported, then drain
  task automatic t_overrun();
    busy = 1'b1;
    mark();
    repeat (5) put(OP_RESET);
    check("uart full", {15'h0000, csi_ready}, 16'h0000);
    check("overrun", {14'h0000, last_st}, {14'h0000, ST_OVERRUN});
    mark();
    busy = 1'b0;
    expect_out("drain", ST_OK, 0, 0);
  endtask : t_overrun

  // Main sequence after the initial reset
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_csi();
    t_uart();
    t_crystal();
    t_overrun();
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    results();
  end
endmodule : flash_program_port_security_tb_top
